// >>> isf_pkg.sv
package isf_pkg;

  // ****************************************************************
  // Register map (printed offsets are indices, byte address = 4 x index)
  // ****************************************************************
  localparam logic [7:0] ISF_SRC_IDX = 8'h80;
  localparam logic [7:0] ISF_MASK_IDX = 8'h93;
  localparam logic [31:0] ISF_SRC_ADDR = {22'h000000, ISF_SRC_IDX, 2'b00};
  localparam logic [31:0] ISF_MASK_ADDR = {22'h000000, ISF_MASK_IDX, 2'b00};

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] ISF_SRC_RESET = 8'h0C;
  localparam logic [7:0] ISF_MASK_RESET = 8'hFF;

  // ****************************************************************
  // Field positions of the source and mask registers
  // ****************************************************************
  localparam int ISF_BIT_USB_EVENT = 7;
  localparam int ISF_BIT_SETUP = 6;
  localparam int ISF_BIT_RESERVED = 5;
  localparam int ISF_BIT_DRIVE_IRQ = 4;
  localparam int ISF_BIT_BUF_B_OUT = 3;
  localparam int ISF_BIT_BUF_A_OUT = 2;
  localparam int ISF_BIT_BUF_B_IN = 1;
  localparam int ISF_BIT_BUF_A_IN = 0;

  // ****************************************************************
  // AHB-Lite encodings
  // ****************************************************************
  localparam logic [1:0] ISF_HTRANS_NONSEQ = 2'h2;
  localparam logic ISF_HRESP_OKAY = 1'b0;

  // ****************************************************************
  // Data phase sequencer
  // ****************************************************************
  typedef enum logic [3:0] {
    ISF_ST_IDLE = 4'b0001,
    ISF_ST_WRITE = 4'b0010,
    ISF_ST_RD_WAIT = 4'b0100,
    ISF_ST_RD_DONE = 4'b1000
  } isf_state_t;

endpackage : isf_pkg

// >>> isf_irq0_source_flags.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps

module isf_irq0_source_flags (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic I_HREADY,
  input wire logic [31:0] I_HWDATA,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_USB_EVENT_PENDING,
  input wire logic I_SETUP_RX,
  input wire logic I_EP0_DATA_RX,
  input wire logic I_DRIVE_INTERRUPT_FLAG,
  input wire logic I_BUF_B_OUTPUT_DONE,
  input wire logic I_BUF_A_OUTPUT_DONE,
  input wire logic I_BUF_B_INPUT_DONE,
  input wire logic I_BUF_A_INPUT_DONE,
  input wire logic I_AUTO_TRANSFER,
  input wire logic I_AUTO_CLR_B_INPUT,
  input wire logic I_AUTO_CLR_A_INPUT,
  input wire logic I_READ_BUFFER_SELECT_TOGGLE_WR,
  input wire logic I_READ_BUFFER_SELECT_TOGGLE_VAL,
  output logic O_CORE_IRQ_INPUT_ZERO,
  output logic O_CONTROL_ENDPOINT_RX_FLAG_SET,
  output logic O_CONTROL_ENDPOINT_RX_BLOCK
);

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  isf_pkg::isf_state_t state_q;
  isf_pkg::isf_state_t state_d;
  logic [31:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  wire accept = I_HSEL && I_HREADY && (I_HTRANS == isf_pkg::ISF_HTRANS_NONSEQ);
  wire hit_src_q = (addr_q == isf_pkg::ISF_SRC_ADDR);
  wire hit_mask_q = (addr_q == isf_pkg::ISF_MASK_ADDR);
  wire wr_src = (state_q == isf_pkg::ISF_ST_WRITE) && hit_src_q;
  wire wr_mask = (state_q == isf_pkg::ISF_ST_WRITE) && hit_mask_q;
  wire rd_src = (state_q == isf_pkg::ISF_ST_RD_WAIT) && hit_src_q;
  wire [7:0] wr1 = wr_src ? I_HWDATA[7:0] : 8'h00;

  // Reads take one wait state so read data comes from a flip-flop
  assign O_HREADYOUT = (state_q != isf_pkg::ISF_ST_RD_WAIT);
  assign O_HRESP = isf_pkg::ISF_HRESP_OKAY;
  assign O_HRDATA = hrdata_q;

  // Next data phase state
  always_comb
  begin
    state_d = isf_pkg::ISF_ST_IDLE;
    unique case (state_q)
      isf_pkg::ISF_ST_RD_WAIT:
      begin
        state_d = isf_pkg::ISF_ST_RD_DONE;
      end
      isf_pkg::ISF_ST_IDLE, isf_pkg::ISF_ST_WRITE, isf_pkg::ISF_ST_RD_DONE:
      begin
        if (accept)
        begin
          state_d = I_HWRITE ? isf_pkg::ISF_ST_WRITE : isf_pkg::ISF_ST_RD_WAIT;
        end
      end
      default:
      begin
        state_d = isf_pkg::ISF_ST_IDLE;
      end
    endcase
  end

  // Address phase capture and sequencer
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      state_q <= isf_pkg::ISF_ST_IDLE;
      addr_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      if (accept)
      begin
        addr_q <= I_HADDR;
      end
    end
  end

  // ****************************************************************
  // Source and mask registers
  // ****************************************************************
  logic setup_q;
  logic dup_q;
  logic drive_q;
  logic drive_prev_q;
  logic buf_b_out_q;
  logic buf_a_out_q;
  logic buf_b_in_q;
  logic buf_a_in_q;
  logic [7:0] mask_q;
  logic setup_d;
  wire [7:0] src_view;

  // Duplicate SETUP: one low cycle then high again
  wire setup_dup = I_SETUP_RX && setup_q && !dup_q;
  always_comb
  begin
    setup_d = setup_q;
    if (dup_q)
    begin
      setup_d = 1'b1;
    end
    else if (setup_dup)
    begin
      setup_d = 1'b0;
    end
    else if (I_SETUP_RX)
    begin
      setup_d = 1'b1;
    end
    else if (wr1[isf_pkg::ISF_BIT_SETUP])
    begin
      setup_d = 1'b0;
    end
  end

  // Set and clear terms of the other flags; set wins everywhere
  wire drive_rise = I_DRIVE_INTERRUPT_FLAG && !drive_prev_q;
  wire drive_d = drive_rise || (drive_q && !wr1[isf_pkg::ISF_BIT_DRIVE_IRQ]);
  wire tog_one = I_READ_BUFFER_SELECT_TOGGLE_WR && I_READ_BUFFER_SELECT_TOGGLE_VAL;
  wire tog_zero = I_READ_BUFFER_SELECT_TOGGLE_WR && !I_READ_BUFFER_SELECT_TOGGLE_VAL;
  // Writing 1 to bits 3 and 2 restores their reset value of one
  wire buf_b_out_d = I_BUF_B_OUTPUT_DONE || wr1[isf_pkg::ISF_BIT_BUF_B_OUT] || (buf_b_out_q && !tog_one);
  wire buf_a_out_d = I_BUF_A_OUTPUT_DONE || wr1[isf_pkg::ISF_BIT_BUF_A_OUT] || (buf_a_out_q && !tog_zero);
  wire clr_b_in = wr1[isf_pkg::ISF_BIT_BUF_B_IN] || (I_AUTO_TRANSFER && I_AUTO_CLR_B_INPUT);
  wire clr_a_in = wr1[isf_pkg::ISF_BIT_BUF_A_IN] || (I_AUTO_TRANSFER && I_AUTO_CLR_A_INPUT);
  wire buf_b_in_d = I_BUF_B_INPUT_DONE || (buf_b_in_q && !clr_b_in);
  wire buf_a_in_d = I_BUF_A_INPUT_DONE || (buf_a_in_q && !clr_a_in);

  // Flag storage
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      setup_q <= isf_pkg::ISF_SRC_RESET[isf_pkg::ISF_BIT_SETUP];
      dup_q <= 1'b0;
      drive_q <= isf_pkg::ISF_SRC_RESET[isf_pkg::ISF_BIT_DRIVE_IRQ];
      drive_prev_q <= 1'b0;
      buf_b_out_q <= isf_pkg::ISF_SRC_RESET[isf_pkg::ISF_BIT_BUF_B_OUT];
      buf_a_out_q <= isf_pkg::ISF_SRC_RESET[isf_pkg::ISF_BIT_BUF_A_OUT];
      buf_b_in_q <= isf_pkg::ISF_SRC_RESET[isf_pkg::ISF_BIT_BUF_B_IN];
      buf_a_in_q <= isf_pkg::ISF_SRC_RESET[isf_pkg::ISF_BIT_BUF_A_IN];
    end
    else
    begin
      setup_q <= setup_d;
      dup_q <= setup_dup;
      drive_q <= drive_d;
      drive_prev_q <= I_DRIVE_INTERRUPT_FLAG;
      buf_b_out_q <= buf_b_out_d;
      buf_a_out_q <= buf_a_out_d;
      buf_b_in_q <= buf_b_in_d;
      buf_a_in_q <= buf_a_in_d;
    end
  end

  // Mask register, all sources masked after reset
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      mask_q <= isf_pkg::ISF_MASK_RESET;
    end
    else if (wr_mask)
    begin
      mask_q <= I_HWDATA[7:0];
    end
  end

  // Register view: live USB summary, reserved bit zero
  assign src_view = {I_USB_EVENT_PENDING, setup_q, 1'b0, drive_q, buf_b_out_q, buf_a_out_q, buf_b_in_q, buf_a_in_q};

  // Read data selection, unmapped reads return zero
  assign rd_mux = hit_src_q ? {24'h000000, src_view} : (hit_mask_q ? {24'h000000, mask_q} : 32'h00000000);

  // Read data register
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      hrdata_q <= 32'h00000000;
    end
    else if (state_q == isf_pkg::ISF_ST_RD_WAIT)
    begin
      hrdata_q <= rd_mux;
    end
  end

  // ****************************************************************
  // Outputs to the core and the endpoint-0 receiver
  // ****************************************************************
  // Mask only gates the output, flags set regardless
  assign O_CORE_IRQ_INPUT_ZERO = |(src_view & ~mask_q);
  // Endpoint-0 data is held off while the SETUP flag stands
  assign O_CONTROL_ENDPOINT_RX_BLOCK = setup_q;
  assign O_CONTROL_ENDPOINT_RX_FLAG_SET = I_EP0_DATA_RX && !setup_q && !I_SETUP_RX;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  wire others_idle = ((src_view & ~mask_q & 8'hBF) == 8'h00);
  wire no_events = !I_USB_EVENT_PENDING && !I_DRIVE_INTERRUPT_FLAG && !I_BUF_B_OUTPUT_DONE
                   && !I_BUF_A_OUTPUT_DONE && !I_BUF_B_INPUT_DONE && !I_BUF_A_INPUT_DONE;

  a_usb_summary_read: assert property (rd_src |=> hrdata_q[7] == $past(I_USB_EVENT_PENDING))
    else $error("bit 7 read does not follow USB event level");
  a_setup_first_set: assert property (I_SETUP_RX && !setup_q && !dup_q |=> setup_q && !O_CONTROL_ENDPOINT_RX_FLAG_SET)
    else $error("SETUP did not set bit 6");
  a_dup_low_high: assert property (setup_dup |=> !setup_q ##1 setup_q)
    else $error("duplicate SETUP did not pulse bit 6 low then high");
  a_dup_irq_edge: assert property (setup_dup && others_idle && no_events && !mask_q[6] |-> O_CORE_IRQ_INPUT_ZERO ##1 !O_CORE_IRQ_INPUT_ZERO)
    else $error("duplicate SETUP gave no interrupt edge");
  a_ep0_held_off: assert property (O_CONTROL_ENDPOINT_RX_FLAG_SET |-> !setup_q && !O_CONTROL_ENDPOINT_RX_BLOCK)
    else $error("endpoint-0 flag set while SETUP flag stands");
  a_reserved_zero: assert property (rd_src |=> !hrdata_q[5])
    else $error("reserved bit 5 read nonzero");
  a_drive_set: assert property ($rose(I_DRIVE_INTERRUPT_FLAG) |=> drive_q)
    else $error("drive interrupt did not set bit 4");
  a_buf_b_toggle: assert property (tog_one && !I_BUF_B_OUTPUT_DONE && !wr1[3] |=> !buf_b_out_q)
    else $error("toggle write of 1 did not clear bit 3");
  a_buf_a_toggle: assert property (tog_zero && !I_BUF_A_OUTPUT_DONE && !wr1[2] |=> !buf_a_out_q)
    else $error("toggle write of 0 did not clear bit 2");
  a_auto_clear_b: assert property (I_AUTO_TRANSFER && I_AUTO_CLR_B_INPUT && !I_BUF_B_INPUT_DONE |=> !buf_b_in_q)
    else $error("auto transfer clear of bit 1 failed");
  a_auto_clear_a: assert property (!I_AUTO_TRANSFER && !wr1[0] && buf_a_in_q |=> buf_a_in_q)
    else $error("bit 0 cleared outside auto transfer");
  a_write_one_por: assert property (wr_src && I_HWDATA[3] |=> buf_b_out_q ##1 1'b1)
    else $error("write of 1 did not restore bit 3 reset value");
  a_write_zero_keep: assert property (wr_src && !I_HWDATA[4] && drive_q |=> drive_q)
    else $error("write of 0 changed bit 4");
  a_irq_all_masked: assert property (mask_q == 8'hFF |-> !O_CORE_IRQ_INPUT_ZERO)
    else $error("interrupt raised while all sources masked");
  a_irq_unmasked: assert property (wr_mask && I_HWDATA[7:0] == 8'h00 && |src_view |=> O_CORE_IRQ_INPUT_ZERO || src_view == 8'h00)
    else $error("unmasked flag gave no interrupt");
  a_masked_still_set: assert property (I_BUF_A_INPUT_DONE && mask_q[0] |=> buf_a_in_q)
    else $error("masked source did not set its flag");
  a_set_wins: assert property (I_BUF_B_INPUT_DONE && clr_b_in |=> buf_b_in_q)
    else $error("clear beat a same-cycle set");

  c_dup_setup: cover property (setup_dup ##1 !setup_q ##1 setup_q);
  c_read_src: cover property (accept && !I_HWRITE && I_HADDR == isf_pkg::ISF_SRC_ADDR ##2 O_HREADYOUT);
  c_irq_rise: cover property (!O_CORE_IRQ_INPUT_ZERO ##1 O_CORE_IRQ_INPUT_ZERO);
  c_set_vs_clear: cover property (I_BUF_A_INPUT_DONE && wr1[0]);
  c_write_mask: cover property (wr_mask ##1 O_CORE_IRQ_INPUT_ZERO);

  // ****************************************************************
  // Further checks on the bus, the flags and the outputs
  // ****************************************************************

  // Bus timing: reads wait one cycle, writes none
  a_hresp_okay: assert property (O_HRESP == isf_pkg::ISF_HRESP_OKAY)
    else $error("response other than OKAY");
  a_read_wait: assert property (accept && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
    else $error("read did not take exactly one wait state");
  a_write_no_wait: assert property (accept && I_HWRITE |=> O_HREADYOUT)
    else $error("write data phase was stretched");
  a_hrdata_upper: assert property (O_HRDATA[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  a_unmapped_zero: assert property (state_q == isf_pkg::ISF_ST_RD_WAIT && !hit_src_q && !hit_mask_q |=> hrdata_q == 32'h00000000)
    else $error("unmapped read returned nonzero");

  // Mask storage and its effect on the interrupt line
  a_mask_store: assert property (wr_mask |=> mask_q == $past(I_HWDATA[7:0]))
    else $error("mask write not stored");
  a_irq_drop: assert property (O_CORE_IRQ_INPUT_ZERO && wr_mask && I_HWDATA[7:0] == 8'hFF |=> !O_CORE_IRQ_INPUT_ZERO)
    else $error("interrupt stayed high after masking all");
  a_irq_needs_flag: assert property (O_CORE_IRQ_INPUT_ZERO |-> |src_view)
    else $error("interrupt high with no flag set");

  // Hardware events set their flags; auto transfer clears bit 0
  a_buf_b_out_set: assert property (I_BUF_B_OUTPUT_DONE |=> buf_b_out_q)
    else $error("buffer B output done did not set bit 3");
  a_buf_a_out_set: assert property (I_BUF_A_OUTPUT_DONE |=> buf_a_out_q)
    else $error("buffer A output done did not set bit 2");
  a_buf_b_in_set: assert property (I_BUF_B_INPUT_DONE |=> buf_b_in_q)
    else $error("buffer B input done did not set bit 1");
  a_buf_a_in_set: assert property (I_BUF_A_INPUT_DONE |=> buf_a_in_q)
    else $error("buffer A input done did not set bit 0");
  a_auto_clear_a_on: assert property (I_AUTO_TRANSFER && I_AUTO_CLR_A_INPUT && !I_BUF_A_INPUT_DONE |=> !buf_a_in_q)
    else $error("auto transfer clear of bit 0 failed");
  a_tog_set_wins: assert property (tog_one && I_BUF_B_OUTPUT_DONE |=> buf_b_out_q)
    else $error("toggle clear beat a same-cycle set");

  // Firmware write of one restores reset values, zero keeps them
  a_write_one_a_out: assert property (wr_src && I_HWDATA[2] |=> buf_a_out_q)
    else $error("write of 1 did not restore bit 2 reset value");
  a_write_one_drive: assert property (wr_src && I_HWDATA[4] && !drive_rise |=> !drive_q)
    else $error("write of 1 did not clear bit 4");
  a_write_one_setup: assert property (wr_src && I_HWDATA[6] && !I_SETUP_RX && !dup_q |=> !setup_q)
    else $error("write of 1 did not clear bit 6");
  a_write_zero_b_in: assert property (wr_src && !I_HWDATA[1] && buf_b_in_q && !(I_AUTO_TRANSFER && I_AUTO_CLR_B_INPUT) |=> buf_b_in_q)
    else $error("write of 0 changed bit 1");
  a_write_zero_a_out: assert property (wr_src && !I_HWDATA[2] && buf_a_out_q && !tog_zero |=> buf_a_out_q)
    else $error("write of 0 changed bit 2");
  a_drive_level_hold: assert property (I_DRIVE_INTERRUPT_FLAG && drive_prev_q && wr1[4] |=> !drive_q)
    else $error("steady drive interrupt level set bit 4 again");

  // SETUP flag and endpoint-0 receive path
  a_ep0_setup_same: assert property (I_SETUP_RX |-> !O_CONTROL_ENDPOINT_RX_FLAG_SET)
    else $error("endpoint-0 flag set by a SETUP packet");
  a_ep0_flag_pass: assert property (I_EP0_DATA_RX && !setup_q && !I_SETUP_RX |-> O_CONTROL_ENDPOINT_RX_FLAG_SET)
    else $error("endpoint-0 data packet not flagged after clear");
  a_dup_absorbed: assert property (dup_q |=> setup_q)
    else $error("bit 6 did not return high after duplicate");

endmodule : isf_irq0_source_flags

// >>> isf_core_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Core interrupt-0 input, configured edge triggered
// ****************************************************************
module isf_core_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_irq,
  output int o_edges
);
  logic irq_q;

  // Counts each rising edge seen on the interrupt line
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      irq_q <= 1'b0;
      o_edges <= 0;
    end
    else
    begin
      irq_q <= i_irq;
      if (i_irq && !irq_q)
        o_edges <= o_edges + 1;
    end
  end
endmodule : isf_core_model

// >>> tb_irq0_source_flags.sv
`timescale 1ns/1ps

module tb_irq0_source_flags;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [9:0] ev = 10'h000;
  logic pend = 1'b0;
  logic auto = 1'b0;
  logic tval = 1'b0;
  wire [31:0] hrdata;
  wire hready;
  wire hresp;
  wire irq;
  wire fset;
  wire blk;
  int edges;
  int errors = 0;
  int comparisons = 0;
  int seed = 62;
  logic fs;
  logic [31:0] m;
  int e0;
  localparam logic [31:0] SRC = isf_pkg::ISF_SRC_ADDR;
  localparam logic [31:0] MSK = isf_pkg::ISF_MASK_ADDR;

  // Clock of 50 ns period
  always #25 clk = ~clk;

  isf_irq0_source_flags isf_irq0_source_flags_i (
    .I_SYS_CLK(clk), .I_RESETN(rstn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HREADY(hready), .I_HWDATA(hwdata), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_USB_EVENT_PENDING(pend), .I_SETUP_RX(ev[5]),
    .I_EP0_DATA_RX(ev[9]), .I_DRIVE_INTERRUPT_FLAG(ev[4]), .I_BUF_B_OUTPUT_DONE(ev[3]),
    .I_BUF_A_OUTPUT_DONE(ev[2]), .I_BUF_B_INPUT_DONE(ev[1]), .I_BUF_A_INPUT_DONE(ev[0]),
    .I_AUTO_TRANSFER(auto), .I_AUTO_CLR_B_INPUT(ev[7]), .I_AUTO_CLR_A_INPUT(ev[6]),
    .I_READ_BUFFER_SELECT_TOGGLE_WR(ev[8]), .I_READ_BUFFER_SELECT_TOGGLE_VAL(tval),
    .O_CORE_IRQ_INPUT_ZERO(irq), .O_CONTROL_ENDPOINT_RX_FLAG_SET(fset), .O_CONTROL_ENDPOINT_RX_BLOCK(blk));

  isf_core_model isf_core_model_i (.i_clk(clk), .i_resetn(rstn), .i_irq(irq), .o_edges(edges));

  // ****************************************************************
  // Checking, bus and event tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Waits for hready high at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      end_of_test();
    end
  endtask : wait_rdy

  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= isf_pkg::ISF_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h0, r);
    check(r, exp, msg);
  endtask : rd

  // One-cycle event pulse; flag-set output is sampled mid pulse
  task automatic pulse(input logic [9:0] p);
    ev <= p;
    @(negedge clk);
    fs = fset;
    @(posedge clk);
    ev <= 10'h000;
    @(posedge clk);
  endtask : pulse

  function automatic logic [31:0] exp_irq(input logic [7:0] s, input logic [7:0] k);
    return {31'h0, |(s & ~k)};
  endfunction : exp_irq

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(SRC, 32'h0000000C, "source reset");
    rd(MSK, 32'h000000FF, "mask reset");
    rd(32'h00000300, 32'h0, "unmapped");
    check({31'h0, hresp}, {31'h0, isf_pkg::ISF_HRESP_OKAY}, "okay response");
    $display("test reset done");
    pend <= 1'b1;
    pulse(10'h03F);
    rd(SRC, 32'h000000DF, "all events");
    check({31'h0, irq}, 32'h0, "masked irq");
    pulse(10'h200);
    check({31'h0, fs}, 32'h0, "ep0 flag with setup");
    check({31'h0, blk}, 32'h1, "ep0 block");
    wr(MSK, 32'h0000007F);
    @(posedge clk);
    check({31'h0, irq}, 32'h1, "event irq");
    wr(SRC, 32'h000000FF);
    rd(SRC, 32'h0000008C, "write one");
    pend <= 1'b0;
    rd(SRC, 32'h0000000C, "event gone");
    $display("test events done");
    for (int i = 0; i < 6; i++)
    begin
      m = {24'h0, 8'($random(seed))};
      wr(MSK, m);
      rd(MSK, m, "mask value");
      check({31'h0, irq}, exp_irq(8'h0C, m[7:0]), "random mask irq");
    end
    $display("test masks done");
    tval <= 1'b1;
    pulse(10'h100);
    rd(SRC, 32'h00000004, "toggle one");
    tval <= 1'b0;
    pulse(10'h100);
    rd(SRC, 32'h00000000, "toggle zero");
    pulse(10'h003);
    pulse(10'h0C0);
    rd(SRC, 32'h00000003, "no auto clear");
    auto <= 1'b1;
    pulse(10'h0C0);
    auto <= 1'b0;
    rd(SRC, 32'h00000000, "auto clear");
    pulse(10'h200);
    check({31'h0, fs}, 32'h1, "ep0 flag");
    $display("test buffers done");
    wr(MSK, 32'h000000BF);
    e0 = edges;
    pulse(10'h020);
    pulse(10'h020);
    repeat (3) @(posedge clk);
    check(edges - e0, 32'h2, "duplicate setup edges");
    rd(SRC, 32'h00000040, "setup held");
    $display("test setup done");
    end_of_test();
  end
endmodule : tb_irq0_source_flags
